// ==== hdl/hvc_config_regs.sv ====
// two indirect 8-bit high-voltage configuration registers and their controls
// assumes a command engine that strobes one command byte with the staged data
`timescale 1ns/1ps
`default_nettype none
`include "hvc_consts.svh"

// one indirect configuration register; the next value is offered so that
// decoded controls can be registered in the same cycle as the register
module hvc_cfg_reg
  import hvc_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = `HVC_CFG_RESET
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // write strobe and staged data
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  // register value, next and current
  output logic [7:0] cfg_d_o,
  output logic [7:0] cfg_q_o
);
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;

  // only a completed write command changes the register
  always_comb begin
    cfg_d = cfg_q;
    if (wr_en_i) begin
      cfg_d = wr_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q <= RESET_VAL;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg_d_o = cfg_d;
  assign cfg_q_o = cfg_q;
endmodule

module hvc_config_regs
  import hvc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // command byte strobe and staged data
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic [7:0] stage_data_i,
  // command completion
  output logic busy_o,
  output logic cmd_ok_o,
  output logic rd_valid_o,
  output hvc_data_type rd_data_o,
  // controls to the high-voltage circuits
  output hvc_ctrl_type ctrl_o,
  output logic [7:0] hv_config_a_o,
  output logic [7:0] hv_config_b_o
);
  // command decode
  logic cmd_take;
  logic wr_a_en;
  logic wr_b_en;
  logic rd_a_en;
  logic rd_b_en;
  logic cmd_known;
  // configuration registers, current and next
  logic [7:0] cfg_a_q;
  logic [7:0] cfg_a_d;
  logic [7:0] cfg_b_q;
  logic [7:0] cfg_b_d;
  // command status
  logic busy_q;
  logic busy_d;
  logic ok_q;
  logic ok_d;
  // readback word
  logic rdv_q;
  logic rdv_d;
  hvc_data_type rd_q;
  hvc_data_type rd_d;
  // controls to the high-voltage circuits
  hvc_ctrl_type ctrl_q;
  hvc_ctrl_type ctrl_d;

  // a command is taken only while idle; anything presented while busy is dropped
  always_comb begin
    cmd_take = cmd_valid_i && !busy_q;
    wr_a_en = 1'b0;
    wr_b_en = 1'b0;
    rd_a_en = 1'b0;
    rd_b_en = 1'b0;
    cmd_known = 1'b1;
    unique case (cmd_byte_i)
      `HVC_CMD_RD_A: begin
        rd_a_en = cmd_take;
      end
      `HVC_CMD_RD_B: begin
        rd_b_en = cmd_take;
      end
      `HVC_CMD_WR_A: begin
        wr_a_en = cmd_take;
      end
      `HVC_CMD_WR_B: begin
        wr_b_en = cmd_take;
      end
      default: begin
        cmd_known = 1'b0;
      end
    endcase
  end

  // the registers sit behind the command interface only, never in the map
  hvc_cfg_reg #(
    .RESET_VAL(`HVC_CFG_RESET)
  ) hvc_cfg_reg_a_inst (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(wr_a_en),
    .wr_data_i(stage_data_i),
    .cfg_d_o(cfg_a_d),
    .cfg_q_o(cfg_a_q)
  );

  hvc_cfg_reg #(
    .RESET_VAL(`HVC_CFG_RESET)
  ) hvc_cfg_reg_b_inst (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(wr_b_en),
    .wr_data_i(stage_data_i),
    .cfg_d_o(cfg_b_d),
    .cfg_q_o(cfg_b_q)
  );

  // busy stands for the one executing cycle; ok records the last taken command
  always_comb begin
    busy_d = cmd_take;
    ok_d = ok_q;
    if (cmd_take) begin
      ok_d = cmd_known;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      ok_q <= ok_d;
    end
  end

  // a read copies the register and its command nibble into the data word
  always_comb begin
    rdv_d = rd_a_en || rd_b_en;
    rd_d = rd_q;
    if (rd_a_en) begin
      rd_d = '{cmd: cmd_byte_i[3:0], data: cfg_a_q};
    end else if (rd_b_en) begin
      rd_d = '{cmd: cmd_byte_i[3:0], data: cfg_b_q};
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdv_q <= 1'b0;
      rd_q <= '0;
    end else begin
      rdv_q <= rdv_d;
      rd_q <= rd_d;
    end
  end

  // controls decoded from the next values so they change with the register
  always_comb begin
    ctrl_d.thermal_shutdown_en = !cfg_a_d[`HVC_A_THERM_DIS];
    ctrl_d.precision_osc_en = cfg_a_d[`HVC_A_OSC_EN];
    ctrl_d.bit_serial_device_mode = cfg_a_d[`HVC_A_BSD_EN];
    ctrl_d.lin_pullup_en = !cfg_a_d[`HVC_A_BSD_EN];
    ctrl_d.wake_pin_high = cfg_a_d[`HVC_A_WAKE];
    ctrl_d.supply_monitor_en = cfg_a_d[`HVC_A_PSM_EN];
    ctrl_d.low_voltage_flag_en = cfg_a_d[`HVC_A_LVF_EN];
    // reserved codes leave the driver off
    ctrl_d.lin_driver_en =
      (cfg_a_d[`HVC_A_LIN_HI:`HVC_A_LIN_LO] == `HVC_LIN_ON);
    ctrl_d.atten_diag_en = cfg_b_d[`HVC_B_ATT_DIAG];
    ctrl_d.hv_temp_monitor_en = cfg_b_d[`HVC_B_TMON_EN];
  end

  // reset value is the decode of cleared registers: shutdown armed, pull-up on
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= `HVC_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign busy_o = busy_q;
  assign cmd_ok_o = ok_q;
  assign rd_valid_o = rdv_q;
  assign rd_data_o = rd_q;
  assign ctrl_o = ctrl_q;
  assign hv_config_a_o = cfg_a_q;
  assign hv_config_b_o = cfg_b_q;
endmodule
`default_nettype wire

// ==== pkg/hvc_consts.svh ====
// constants for the high-voltage indirect configuration bank
// assumes inclusion by its bare name from the package and the design
`ifndef HVC_CONSTS_SVH
`define HVC_CONSTS_SVH
`define HVC_CFG_RESET 8'h00
`define HVC_CTRL_RESET 10'h240
`define HVC_CMD_RD_A 8'h00
`define HVC_CMD_RD_B 8'h01
`define HVC_CMD_WR_A 8'h08
`define HVC_CMD_WR_B 8'h09
`define HVC_A_THERM_DIS 7
`define HVC_A_OSC_EN 6
`define HVC_A_BSD_EN 5
`define HVC_A_WAKE 4
`define HVC_A_PSM_EN 3
`define HVC_A_LVF_EN 2
`define HVC_A_LIN_HI 1
`define HVC_A_LIN_LO 0
`define HVC_B_ATT_DIAG 7
`define HVC_B_TMON_EN 6
`define HVC_LIN_OFF 2'h0
`define HVC_LIN_ON 2'h2
`endif

// ==== pkg/hvc_pkg.sv ====
// types for the high-voltage indirect configuration bank
// assumes nothing beyond the constants header
`include "hvc_consts.svh"
package hvc_pkg;
  typedef struct packed {
    logic thermal_shutdown_en;
    logic precision_osc_en;
    logic bit_serial_device_mode;
    logic lin_pullup_en;
    logic wake_pin_high;
    logic supply_monitor_en;
    logic low_voltage_flag_en;
    logic lin_driver_en;
    logic atten_diag_en;
    logic hv_temp_monitor_en;
  } hvc_ctrl_type;
  typedef struct packed {
    logic [3:0] cmd;
    logic [7:0] data;
  } hvc_data_type;
endpackage

// ==== tb/hvc_chk_assertions.sv ====
// checker for the indirect config bank
// assumes binding onto hvc_config_regs
`timescale 1ns/1ps
`default_nettype none
module hvc_chk
  import hvc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // command inputs of the bank
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic [7:0] stage_data_i,
  // outputs of the bank
  input wire logic busy_o,
  input wire logic cmd_ok_o,
  input wire logic rd_valid_o,
  input wire hvc_data_type rd_data_o,
  input wire hvc_ctrl_type ctrl_o,
  input wire logic [7:0] hv_config_a_o,
  input wire logic [7:0] hv_config_b_o
);
  wire t = cmd_valid_i && !busy_o;
  wire wa = t && cmd_byte_i == 8'h08;
  wire wb = t && cmd_byte_i == 8'h09;
  wire ra = t && cmd_byte_i == 8'h00;
  wire rb = t && cmd_byte_i == 8'h01;
  wire known = wa || wb || ra || rb;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  wr_a_a: assert property (wa |=> hv_config_a_o == $past(stage_data_i))
    else $error("wr a");
  wr_b_a: assert property (wb |=> hv_config_b_o == $past(stage_data_i))
    else $error("wr b");
  keep_a_a: assert property (!wa |=> $stable(hv_config_a_o))
    else $error("keep a");
  keep_b_a: assert property (!wb |=> $stable(hv_config_b_o))
    else $error("keep b");
  busy_pulse_a: assert property (t |=> busy_o ##1 !busy_o)
    else $error("busy");
  rd_a_a: assert property (ra |=> rd_data_o == {4'h0, hv_config_a_o})
    else $error("rd a");
  rd_b_a: assert property (rb |=> rd_data_o == {4'h1, hv_config_b_o})
    else $error("rd b");
  rd_pulse_a: assert property ((ra || rb) |=> rd_valid_o)
    else $error("rd valid");
  rd_quiet_a: assert property (!(ra || rb) |=> !rd_valid_o)
    else $error("rd quiet");
  cmd_ok_a: assert property (known |=> cmd_ok_o)
    else $error("cmd ok");
  cmd_bad_a: assert property (t && !known |=> !cmd_ok_o)
    else $error("cmd bad");
  therm_a: assert property (ctrl_o.thermal_shutdown_en != hv_config_a_o[7])
    else $error("th");
  pullup_map_a: assert property (ctrl_o.lin_pullup_en != hv_config_a_o[5])
    else $error("pullup");
  wake_map_a: assert property (ctrl_o.wake_pin_high == hv_config_a_o[4])
    else $error("wake");
  lin_a: assert property (ctrl_o.lin_driver_en == (hv_config_a_o[1:0] == 2'h2))
    else $error("lin");
  diag_a: assert property (ctrl_o.atten_diag_en == hv_config_b_o[7])
    else $error("diag");
  tmon_map_a: assert property (ctrl_o.hv_temp_monitor_en == hv_config_b_o[6])
    else $error("tmon");
  cover property (wa);
  cover property (wb);
  cover property (rb);
  cover property (t && !known);
endmodule
bind hvc_config_regs hvc_chk hvc_chk_inst (
  .mclk_i(mclk_i),
  .reset_n_i(reset_n_i),
  .cmd_valid_i(cmd_valid_i),
  .cmd_byte_i(cmd_byte_i),
  .stage_data_i(stage_data_i),
  .busy_o(busy_o),
  .cmd_ok_o(cmd_ok_o),
  .rd_valid_o(rd_valid_o),
  .rd_data_o(rd_data_o),
  .ctrl_o(ctrl_o),
  .hv_config_a_o(hv_config_a_o),
  .hv_config_b_o(hv_config_b_o)
);
`default_nettype wire

// ==== tb/hvc_config_regs_tb_top.sv ====
// bench for the indirect config bank
// assumes the core model drives every command
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t %h %h", $time, a, b); end end
module hvc_config_regs_tb_top;
  import hvc_pkg::*;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, cmd_valid_i, busy_o, cmd_ok_o, rd_valid_o;
  logic [7:0] cmd_byte_i, stage_data_i, hv_config_a_o, hv_config_b_o;
  hvc_data_type rd_data_o;
  hvc_ctrl_type ctrl_o;
  int error_cnt = 0, n_tests = 0;
  always #4 mclk_i = ~mclk_i;
  hvc_config_regs hvc_config_regs_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i), .stage_data_i(stage_data_i),
    .busy_o(busy_o), .cmd_ok_o(cmd_ok_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .ctrl_o(ctrl_o), .hv_config_a_o(hv_config_a_o), .hv_config_b_o(hv_config_b_o));
  hvc_core_model hvc_core_model_inst (.mclk_i, .busy_i(busy_o), .cmd_valid_o(cmd_valid_i),
    .cmd_byte_o(cmd_byte_i), .stage_data_o(stage_data_i));
  task test_done;
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task go(input logic [7:0] c, input logic [7:0] d);
    hvc_core_model_inst.issue(c, d);
  endtask
  task rd(input logic [7:0] c, input logic [7:0] e);
    go(c, 8'h00);
    `CHK(rd_data_o, {c[3:0], e})
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    `CHK(ctrl_o, 10'h240)
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    `CHK(cmd_ok_o, 1'b1)
    for (logic [2:0] i = 0; i < 4; i++) begin
      go(8'h08, {6'h14, i[1:0]});
      `CHK(ctrl_o.lin_driver_en, i == 2)
      rd(8'h00, {6'h14, i[1:0]});
    end
    go(8'h08, 8'hBC);
    go(8'h09, 8'hC0);
    `CHK(ctrl_o, 10'h0BB)
    go(8'h08, 8'h40);
    go(8'h05, 8'hFF);
    `CHK(cmd_ok_o, 1'b0)
    `CHK(ctrl_o, 10'h343)
    rd(8'h00, 8'h40);
    rd(8'h01, 8'hC0);
    `CHK(busy_o, 1'b0)
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    `CHK({hv_config_a_o, hv_config_b_o}, 16'h0000)
    `CHK(ctrl_o, 10'h240)
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(8'h01, 8'h00);
    test_done;
  end
  initial begin
    repeat (3000) @(posedge mclk_i);
    error_cnt++;
    test_done;
  end
endmodule
`default_nettype wire

// ==== tb/hvc_core_model.sv ====
// processor core model issuing indirect commands
// assumes busy_i comes from the config bank
`timescale 1ns/1ps
`default_nettype none
module hvc_core_model (
  input wire logic mclk_i,
  input wire logic busy_i,
  output logic cmd_valid_o,
  output logic [7:0] cmd_byte_o,
  output logic [7:0] stage_data_o
);
  initial {cmd_valid_o, cmd_byte_o, stage_data_o} = 17'h0;
  task issue(input logic [7:0] c, input logic [7:0] d);
    while (busy_i) @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_byte_o <= c;
    stage_data_o <= d;
    @(posedge mclk_i);
    cmd_valid_o <= 1'b0;
    stage_data_o <= ~d;
    repeat (2) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire
